// ---- dmmo_pkg.sv ----
// Constants, encodings and types shared by the data move and multiply executor
package dmmo_pkg;

   // ****************************************
   // Opcode prefixes
   // ****************************************
   localparam logic [3:0] OPC_COPY_SRC  = 4'hC;  // First word of copy_file_to_file
   localparam logic [3:0] OPC_COPY_DST  = 4'hF;  // Second word of copy_file_to_file
   localparam logic [7:0] OPC_LOAD_BANK = 8'h01; // load_bank_literal
   localparam logic [7:0] OPC_LOAD_ACC  = 8'h0E; // load_literal_to_acc
   localparam logic [7:0] OPC_MUL_LIT   = 8'h0D; // multiply_literal_acc
   localparam logic [6:0] OPC_STORE_ACC = 7'h37; // store_acc_to_file, 0110 111a
   localparam logic [6:0] OPC_MUL_FILE  = 7'h01; // multiply_acc_file, 0000 001a

   // ****************************************
   // Instruction field positions
   // ****************************************
   localparam int PFX4_HI  = 15;  // Top of the 4-bit prefix
   localparam int PFX4_LO  = 12;  // Bottom of the 4-bit prefix
   localparam int PFX8_LO  = 8;   // Bottom of the 8-bit prefix
   localparam int PFX7_LO  = 9;   // Bottom of the 7-bit prefix
   localparam int ADDR_HI  = 11;  // Top of a 12-bit address field
   localparam int LIT_HI   = 7;   // Top of an 8-bit literal or file field
   localparam int BANK_BIT = 8;   // Bank-choice bit of file instructions
   localparam int SPLIT_BIT = 7;  // Access bank split: low half / high half

   // ****************************************
   // Data space map
   // ****************************************
   localparam logic [11:0] ACC_ADDR      = 12'hFE8; // Working register's mapped address
   localparam logic [11:0] PC_LOW_ADDR   = 12'hFF9; // program_counter_low
   localparam logic [11:0] STK_UPPER_ADDR = 12'hFFF; // stack_top_upper
   localparam logic [11:0] STK_HIGH_ADDR = 12'hFFE; // stack_top_high
   localparam logic [11:0] STK_LOW_ADDR  = 12'hFFD; // stack_top_low
   localparam logic [3:0]  ACCESS_LO_PAGE = 4'h0;   // Access bank, lower half
   localparam logic [3:0]  ACCESS_HI_PAGE = 4'hF;   // Access bank, upper half

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0]  ACC_RST  = 8'h00;
   localparam logic [7:0]  BANK_RST = 8'h00;
   localparam logic [7:0]  PROD_RST = 8'h00;
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [11:0] ADDR_RST = 12'h000;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      QP_1 = 2'b00,  // Decode
      QP_2 = 2'b01,  // Read
      QP_3 = 2'b10,  // Process
      QP_4 = 2'b11   // Write
   } dmmo_q_t;

   typedef enum logic {
      SEQ_SINGLE = 1'b0,  // Ordinary instruction cycle
      SEQ_COPY2  = 1'b1   // Second word of copy_file_to_file
   } dmmo_seq_t;

endpackage

// ---- dmmo_mult.sv ----
// Unsigned 8x8 multiplier for the product register pair
`timescale 1ns/1ps
module dmmo_mult (
   input  wire logic [7:0]  a_i,  // Working register
   input  wire logic [7:0]  b_i,  // Literal or file operand
   output logic      [15:0] p_o   // Full unsigned product
);
   // Full 16-bit result; neither carry nor overflow can exist
   assign p_o = 16'(a_i) * 16'(b_i);
endmodule

// ---- dmmo_core.sv ----
// Executor for data move, literal load and multiply instructions
`timescale 1ns/1ps

// What this block does
// - Decode two-word copy, prefixes 1100 then 1111
// - Copy addresses span whole 4096-byte space, unbanked
// - Working register usable as copy source or destination
// - Copy: read first cycle, write second Q4
// - Literal into bank select, one cycle, no flags
// - Store working register to banked file, no flags
// - Bank bit zero selects access bank, else bank select
// - Multiply literal by working register into product pair
// - Decode multiply literal from 0000 1101 prefix
// - Multiply keeps working register and flags unchanged
// - Multiply raises no carry, overflow or zero indication
module dmmo_core (
   input  wire logic                 clk_i,          // 25 MHz core clock
   input  wire logic                 rst_n_i,        // Synchronous reset, active low
   input  wire logic [15:0]          instr_i,        // Fetched word, stable during Q1
   input  wire logic [7:0]           dm_rdata_i,     // Data memory read data
   output logic      [1:0]           q_phase_o,      // Current quarter
   output logic      [11:0]          dm_addr_o,      // Data memory address
   output logic                      dm_rd_o,        // Data memory read strobe
   output logic                      dm_wr_o,        // Data memory write strobe
   output logic      [7:0]           dm_wdata_o,     // Data memory write data
   output logic      [7:0]           acc_o,          // Working register
   output logic      [7:0]           bank_select_o,  // bank_select_reg
   output logic      [7:0]           product_high_o, // product_high
   output logic      [7:0]           product_low_o,  // product_low
   output logic                      second_word_o,  // Executing a copy's second word
   output logic                      bad_dest_o      // Copy aimed at a protected byte
);
   import dmmo_pkg::*;

   // ****************************************
   // State
   // ****************************************
   dmmo_q_t     q;          // Quarter counter, the only divider
   dmmo_seq_t   seq;        // Single cycle or copy second word
   logic [15:0] ir;         // Word latched at end of Q1
   logic [7:0]  acc;        // Working register
   logic [7:0]  bank_select_reg;        // bank_select_reg
   logic [7:0]  prod_hi;    // product_high
   logic [7:0]  prod_lo;    // product_low
   logic [7:0]  opd;        // Operand read in Q2, held across a copy
   logic [11:0] addr;       // Registered memory address
   logic        rd;         // Registered read strobe
   logic        wr;         // Registered write strobe
   logic [7:0]  wdata;      // Registered write data
   logic        bad_dest;   // Sticky until next copy destination

   // ****************************************
   // Decode
   // ****************************************
   // During Q1 the fetched word is live; afterwards the latched copy is used
   wire [15:0] word       = (q == QP_1) ? instr_i : ir;
   wire        copy2      = (seq == SEQ_COPY2);
   wire [7:0]  lit        = word[LIT_HI:0];
   // Second words never decode as anything else
   wire        is_copy1   = !copy2 && (word[PFX4_HI:PFX4_LO] == OPC_COPY_SRC);
   wire        dest_ok    = copy2 && (word[PFX4_HI:PFX4_LO] == OPC_COPY_DST);
   wire        is_ldbank  = !copy2 && (word[PFX4_HI:PFX8_LO] == OPC_LOAD_BANK);
   wire        is_ldacc   = !copy2 && (word[PFX4_HI:PFX8_LO] == OPC_LOAD_ACC);
   wire        is_mullit  = !copy2 && (word[PFX4_HI:PFX8_LO] == OPC_MUL_LIT);
   wire        is_stacc   = !copy2 && (word[PFX4_HI:PFX7_LO] == OPC_STORE_ACC);
   wire        is_mulfile = !copy2 && (word[PFX4_HI:PFX7_LO] == OPC_MUL_FILE);
   wire        is_mul     = is_mullit || is_mulfile;
   wire        file_op    = is_stacc || is_mulfile;

   // Access bank splits into low and high halves by the file field's top bit
   wire [3:0]  access_pg  = lit[SPLIT_BIT] ? ACCESS_HI_PAGE : ACCESS_LO_PAGE;
   wire [3:0]  bank_pg    = word[BANK_BIT] ? bank_select_reg[3:0] : access_pg;
   wire [11:0] bank_addr  = {bank_pg, lit};

   // Copy uses the raw 12-bit field; no banking involved
   wire [11:0] full_addr  = word[ADDR_HI:0];
   wire [11:0] rd_addr    = is_copy1 ? full_addr : bank_addr;
   wire        rd_need    = is_copy1 || file_op;
   wire        rd_is_acc  = (rd_addr == ACC_ADDR);
   wire [11:0] wr_addr    = copy2 ? full_addr : bank_addr;
   wire        wr_is_acc  = (wr_addr == ACC_ADDR);
   wire        wr_mem     = (dest_ok || is_stacc) && !wr_is_acc;
   wire [7:0]  wr_val     = copy2 ? opd : acc;
   wire        dest_prot  = (full_addr == PC_LOW_ADDR) || (full_addr == STK_UPPER_ADDR) ||
                            (full_addr == STK_HIGH_ADDR) || (full_addr == STK_LOW_ADDR);

   // ****************************************
   // Multiplier
   // ****************************************
   logic [15:0] product;                           // Combinational product
   wire  [7:0]  mul_b = is_mullit ? lit : opd;     // Literal or file operand

   dmmo_mult u_mult (
      .a_i (acc),
      .b_i (mul_b),
      .p_o (product)
   );

   // ****************************************
   // Quarter divider and sequence
   // ****************************************
   // Free-running quarter counter; every instruction cycle is four clocks
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         q <= QP_1;
      end else begin
         q <= dmmo_q_t'(q + 2'h1);
      end
   end

   // Copy's first word arms the second cycle at the end of Q4
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         seq <= SEQ_SINGLE;
      end else if (q == QP_4) begin
         seq <= is_copy1 ? SEQ_COPY2 : SEQ_SINGLE;
      end
   end

   // ****************************************
   // Quarter actions
   // ****************************************
   // Memory strobes: read in Q2, write in Q4, nothing else
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ir    <= WORD_RST;
         addr  <= ADDR_RST;
         rd    <= 1'b0;
         wr    <= 1'b0;
         wdata <= ACC_RST;
         opd   <= ACC_RST;
      end else begin
         unique case (q)
            QP_1: begin
               // Decode; set up the Q2 read, none in a copy second word
               ir <= instr_i;
               if (rd_need) begin
                  addr <= rd_addr;
                  rd   <= !rd_is_acc;
               end
            end
            QP_2: begin
               // Operand capture; the working register bypasses memory
               rd <= 1'b0;
               if (rd_need) begin
                  opd <= rd_is_acc ? acc : dm_rdata_i;
               end
            end
            QP_3: begin
               // Present the destination for the Q4 write
               if (dest_ok || is_stacc) begin
                  addr  <= wr_addr;
                  wr    <= wr_mem;
                  wdata <= wr_val;
               end
            end
            QP_4: begin
               wr <= 1'b0;
            end
         endcase
      end
   end

   // Register commits at the end of Q4; no status flags exist in this path
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         acc     <= ACC_RST;
         bank_select_reg     <= BANK_RST;
         prod_hi <= PROD_RST;
         prod_lo <= PROD_RST;
      end else if (q == QP_4) begin
         if (is_ldacc) begin
            acc <= lit;
         end else if (dest_ok && wr_is_acc) begin
            acc <= opd;
         end
         if (is_ldbank) begin
            bank_select_reg <= lit;
         end
         // Multiply writes only the pair; accumulator untouched
         if (is_mul) begin
            prod_hi <= product[15:8];
            prod_lo <= product[7:0];
         end
      end
   end

   // Flags a copy aimed at the counter or stack bytes; the write still goes ahead
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         bad_dest <= 1'b0;
      end else if (q == QP_3 && copy2) begin
         bad_dest <= dest_ok && dest_prot;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign q_phase_o      = q;
   assign dm_addr_o      = addr;
   assign dm_rd_o        = rd;
   assign dm_wr_o        = wr;
   assign dm_wdata_o     = wdata;
   assign acc_o          = acc;
   assign bank_select_o  = bank_select_reg;
   assign product_high_o = prod_hi;
   assign product_low_o  = prod_lo;
   assign second_word_o  = seq;
   assign bad_dest_o     = bad_dest;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_copy_write;
      (q == QP_3 && dest_ok && !wr_is_acc) |=> dm_wr_o && dm_addr_o == $past(full_addr)
         && dm_wdata_o == $past(opd);
   endproperty
   a_copy_write: assert property (p_copy_write) else $error("copy write wrong");

   property p_no_dummy_read;
      (copy2 && q == QP_2) |-> !dm_rd_o;
   endproperty
   a_no_dummy_read: assert property (p_no_dummy_read) else $error("dummy read");

   property p_copy_two_cycles;
      (q == QP_4 && is_copy1) |=> copy2 [*4] ##1 !copy2;
   endproperty
   a_copy_two_cycles: assert property (p_copy_two_cycles) else $error("copy length");

   property p_copy_to_acc;
      (q == QP_4 && dest_ok && wr_is_acc) |=> acc == $past(opd) && !dm_wr_o;
   endproperty
   a_copy_to_acc: assert property (p_copy_to_acc) else $error("copy to acc");

   property p_load_bank;
      (q == QP_4 && is_ldbank) |=> bank_select_reg == $past(lit) && $stable(acc);
   endproperty
   a_load_bank: assert property (p_load_bank) else $error("bank load wrong");

   property p_store_acc;
      (q == QP_3 && is_stacc && !wr_is_acc) |=> dm_wr_o && dm_wdata_o == acc;
   endproperty
   a_store_acc: assert property (p_store_acc) else $error("store wrong");

   property p_access_bank;
      (q == QP_1 && file_op && !instr_i[BANK_BIT]) |=>
         dm_addr_o[11:8] == ($past(instr_i[SPLIT_BIT]) ? ACCESS_HI_PAGE : ACCESS_LO_PAGE);
   endproperty
   a_access_bank: assert property (p_access_bank) else $error("access bank");

   property p_mul_lit;
      (q == QP_4 && is_mullit) |=> {prod_hi, prod_lo} == 16'($past(acc)) * 16'($past(lit));
   endproperty
   a_mul_lit: assert property (p_mul_lit) else $error("product wrong");

   property p_mul_keeps;
      (q == QP_4 && is_mul) |=> $stable(acc) && $stable(bank_select_reg);
   endproperty
   a_mul_keeps: assert property (p_mul_keeps) else $error("multiply side effect");

   property p_load_acc;
      (q == QP_4 && is_ldacc) |=> acc == $past(lit);
   endproperty
   a_load_acc: assert property (p_load_acc) else $error("acc load wrong");

   property p_quarters;
      dm_wr_o |-> q == QP_4 ##1 (!dm_wr_o && q == QP_1);
   endproperty
   a_quarters: assert property (p_quarters) else $error("write outside Q4");

   property p_prot_dest;
      (q == QP_3 && dest_ok && dest_prot) |=> bad_dest;
   endproperty
   a_prot_dest: assert property (p_prot_dest) else $error("protected dest not flagged");

   // An ordinary destination clears a flag left by an earlier copy
   property p_clean_dest;
      (q == QP_3 && copy2 && !dest_prot) |=> !bad_dest;
   endproperty
   a_clean_dest: assert property (p_clean_dest) else $error("clean dest flagged");

   // A file multiply takes the byte captured in Q2, not the literal field
   property p_mul_file;
      (q == QP_4 && is_mulfile) |=> {prod_hi, prod_lo} == 16'($past(acc)) * 16'($past(opd));
   endproperty
   a_mul_file: assert property (p_mul_file) else $error("file product wrong");

   // Reads happen only in Q2 and last one clock
   property p_read_q2;
      dm_rd_o |-> q == QP_2 ##1 !dm_rd_o;
   endproperty
   a_read_q2: assert property (p_read_q2) else $error("read outside Q2");

   c_copy:     cover property (q == QP_3 && dest_ok && !wr_is_acc);
   c_copy_acc: cover property (q == QP_4 && dest_ok && wr_is_acc);
   c_mul_lit:  cover property (q == QP_4 && is_mullit);
   c_bank_bsr: cover property (q == QP_1 && file_op && instr_i[BANK_BIT]);
   c_mul_file: cover property (q == QP_4 && is_mulfile);

endmodule

// ---- dmmo_dmem_model.sv ----
// Data memory partner for the data move and multiply executor
`timescale 1ns/1ps
module dmmo_dmem_model (
   input  wire logic        clk_i,      // Core clock
   input  wire logic [11:0] dm_addr_i,  // Byte address
   input  wire logic        dm_rd_i,    // Read strobe, Q2
   input  wire logic        dm_wr_i,    // Write strobe, Q4
   input  wire logic [7:0]  dm_wdata_i, // Write data
   output logic      [7:0]  dm_rdata_o  // Read data
);
   // ****************************************
   // Storage
   // ****************************************
   logic [7:0] mem [0:4095];  // Whole space, no banking
   logic [7:0] last = 8'h5A;  // Last byte driven on the bus

   // Zero-wait read; a released bus shows the inverse, so stale data never matches
   assign dm_rdata_o = dm_rd_i ? mem[dm_addr_i] : ~last;

   // Writes land at the edge that ends Q4
   always @(posedge clk_i) begin
      if (dm_wr_i) begin
         mem[dm_addr_i] <= dm_wdata_i;
      end
      if (dm_rd_i) begin
         last <= mem[dm_addr_i];
      end
   end
endmodule

// ---- dmmo_core_tb.sv ----
// Self-checking bench for the data move and multiply executor
`timescale 1ns/1ps
module dmmo_core_tb;
   import dmmo_pkg::*;

   // ****************************************
   // Signals
   // ****************************************
   logic        clk_i   = 1'b0;     // 25 MHz core clock
   logic        rst_n_i = 1'b0;     // Held low from time zero
   logic [15:0] instr_i = 16'h0000; // Idle word is a no-op
   logic [7:0]  dm_rdata;           // From the memory model
   logic [1:0]  q_phase;            // Current quarter
   logic [11:0] dm_addr;            // Memory address
   logic        dm_rd;              // Read strobe
   logic        dm_wr;              // Write strobe
   logic [7:0]  dm_wdata;           // Write data
   logic [7:0]  acc_o;              // Working register
   logic [7:0]  bank_select_o;      // bank_select_reg
   logic [15:0] prod;               // product_high:product_low
   logic        second_word;        // Copy second word flag
   logic        bad_dest;           // Protected destination flag
   logic [7:0]  rd_seen;            // Read strobe per quarter, two cycles
   logic [7:0]  wr_seen;            // Write strobe per quarter, two cycles
   logic [7:0]  sw_seen;            // Second-word flag per quarter
   logic [7:0]  e_acc  = 8'h00;     // Expected working register
   logic [7:0]  e_bsr  = 8'h00;     // Expected bank select
   logic [15:0] e_prod = 16'h0000;  // Expected product pair
   logic [31:0] r;                  // Random draw
   integer      seed   = 32'hb5af;  // Fixed seed, repeatable run
   integer      errors = 0;         // Mismatch count
   integer      checks = 0;         // Comparison count

   always #20 clk_i = ~clk_i;

   // ****************************************
   // Design and partner
   // ****************************************
   dmmo_core u_dut (
      .clk_i          (clk_i),
      .rst_n_i        (rst_n_i),
      .instr_i        (instr_i),
      .dm_rdata_i     (dm_rdata),
      .q_phase_o      (q_phase),
      .dm_addr_o      (dm_addr),
      .dm_rd_o        (dm_rd),
      .dm_wr_o        (dm_wr),
      .dm_wdata_o     (dm_wdata),
      .acc_o          (acc_o),
      .bank_select_o  (bank_select_o),
      .product_high_o (prod[15:8]),
      .product_low_o  (prod[7:0]),
      .second_word_o  (second_word),
      .bad_dest_o     (bad_dest)
   );

   dmmo_dmem_model u_mem (
      .clk_i      (clk_i),
      .dm_addr_i  (dm_addr),
      .dm_rd_i    (dm_rd),
      .dm_wr_i    (dm_wr),
      .dm_wdata_i (dm_wdata),
      .dm_rdata_o (dm_rdata)
   );

   // ****************************************
   // Helpers
   // ****************************************
   // Verdict and end of run, the only exit
   task automatic stop_test();
      if (errors == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Case equality so an unknown never matches
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Banked file address worked out independently of the design
   function automatic logic [11:0] fa(input logic [7:0] f, input logic a);
      return a ? {e_bsr[3:0], f} : {(f[7] ? ACCESS_HI_PAGE : ACCESS_LO_PAGE), f};
   endfunction

   // Present w1, then w2 right behind it; words change mid Q4 so Q1 sees them steady
   task automatic run(input logic [15:0] w1, input logic [15:0] w2);
      integer n;
      n = 0;
      while (q_phase !== 2'h3 && n < 8) begin
         @(negedge clk_i);
         n = n + 1;
      end
      if (n >= 8) begin
         errors = errors + 1;
         $display("Error at %0t: quarter counter stuck", $time);
         stop_test();
      end
      instr_i = w1;
      for (int i = 0; i < 8; i++) begin
         @(negedge clk_i);
         rd_seen[{i[2], q_phase}] = dm_rd;
         wr_seen[{i[2], q_phase}] = dm_wr;
         sw_seen[{i[2], q_phase}] = second_word;
         if (q_phase === 2'h3) begin
            instr_i = (i < 4) ? w2 : 16'h0000;
         end
      end
      @(negedge clk_i);
   endtask

   // One operation: 0 load acc, 1 load bank, 2 mul literal, 3 store, 4 mul file, 5 copy
   task automatic do_op(input int op, input logic [31:0] rv);
      logic [11:0] src;
      logic [11:0] dst;
      logic [7:0]  f;
      logic [7:0]  v;
      logic [7:0]  erd;
      logic [7:0]  ewr;
      logic [7:0]  esw;
      erd = 8'h00;
      ewr = 8'h00;
      esw = 8'h00;
      f = rv[7:0];
      src = fa(f, rv[8]);
      // Working register alias never reaches memory, so keep file ops off it
      if (src === ACC_ADDR) begin
         f = f ^ 8'h01;
         src = fa(f, rv[8]);
      end
      case (op)
         0: begin
            run({OPC_LOAD_ACC, f}, 16'h0000);
            e_acc = f;
         end
         1: begin
            run({OPC_LOAD_BANK, f}, 16'h0000);
            e_bsr = f;
         end
         2: begin
            run({OPC_MUL_LIT, f}, 16'h0000);
            e_prod = {8'h00, e_acc} * {8'h00, f};
         end
         3: begin
            erd = 8'h02;
            ewr = 8'h08;
            run({OPC_STORE_ACC, rv[8], f}, 16'h0000);
            chk({8'h00, u_mem.mem[src]}, {8'h00, e_acc});
         end
         4: begin
            erd = 8'h02;
            e_prod = {8'h00, e_acc} * {8'h00, u_mem.mem[src]};
            run({OPC_MUL_FILE, rv[8], f}, 16'h0000);
         end
         default: begin
            src = rv[11:0];
            dst = rv[27:16];
            // Stimulus keeps copy destinations off the counter and stack top bytes
            if (dst[11:4] === 8'hFF && (dst[3:0] === 4'h9 || dst[3:0] >= 4'hD)) begin
               dst = dst ^ 12'h010;
            end
            v = (src === ACC_ADDR) ? e_acc : u_mem.mem[src];
            erd = (src === ACC_ADDR) ? 8'h00 : 8'h02;
            ewr = (dst === ACC_ADDR) ? 8'h00 : 8'h80;
            esw = 8'hF0;
            run({OPC_COPY_SRC, src}, {OPC_COPY_DST, dst});
            if (dst === ACC_ADDR) begin
               e_acc = v;
            end else begin
               chk({8'h00, u_mem.mem[dst]}, {8'h00, v});
            end
            // Stimulus never names a protected destination, so the flag must stay low
            chk({15'h0000, bad_dest}, 16'h0000);
         end
      endcase
      chk({acc_o, bank_select_o}, {e_acc, e_bsr});
      chk(prod, e_prod);
      chk({rd_seen, wr_seen}, {erd, ewr});
      chk({8'h00, sw_seen}, {8'h00, esw});
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      for (int i = 0; i < 4096; i++) begin
         r = $random(seed);
         u_mem.mem[i] = r[7:0];
      end
      repeat (20) @(negedge clk_i);
      rst_n_i = 1'b1;
      chk({acc_o, bank_select_o}, 16'h0000);
      chk(prod, 16'h0000);
      // Corner cases first
      do_op(0, 32'h000000E2);
      do_op(2, 32'h000000C4);
      do_op(0, 32'h00000000);
      do_op(2, 32'h000000FF);
      do_op(1, 32'h0000000F);
      do_op(3, 32'h00000110);
      do_op(3, 32'h00000010);
      do_op(4, 32'h00000090);
      do_op(5, 32'h00000FE8);
      do_op(5, 32'h0FE80FFF);
      do_op(5, 32'h0FFC0000);
      do_op(5, 32'h0FF90123);
      // Random mix, every kind in turn
      for (int k = 0; k < 120; k++) begin
         r = $random(seed);
         do_op(k % 6, r);
      end
      stop_test();
   end
endmodule
